// ### design/ppg_pkg.sv
// Purpose: shared constants and types of the pulse generator block
// Assumes: 32-bit axi4-lite register bus, 8-bit byte address
// Notes: control byte layout follows the timer_one_control register
`default_nettype none
package ppg_pkg;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 16;
	localparam int DIV_W = 11;

	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_WIDTH = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;

	// timer_one_control fields
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_CLK_LSB = 2;
	localparam int CTL_START_LSB = 4;
	localparam int CTL_REPEAT_BIT = 6;
	localparam int CTL_INIT_BIT = 7;

	// status fields
	localparam int STAT_FLOP_BIT = 16;
	localparam int STAT_RUN_BIT = 17;
	localparam int STAT_ARMED_BIT = 18;

	// timer_mode_field encodings
	localparam logic [1:0] MODE_TIMER = 2'h0;
	localparam logic [1:0] MODE_PPG = 2'h3;

	// start_control_field encodings
	localparam logic [1:0] START_STOP = 2'h0;
	localparam logic [1:0] START_CMD = 2'h1;
	localparam logic [1:0] START_RISE = 2'h2;
	localparam logic [1:0] START_FALL = 2'h3;

	// source clock divide masks: tick when the masked prescaler bits are all ones
	localparam logic [DIV_W-1:0] DIV_MASK_2K = 11'h7ff;
	localparam logic [DIV_W-1:0] DIV_MASK_128 = 11'h07f;
	localparam logic [DIV_W-1:0] DIV_MASK_8 = 11'h007;
	localparam logic [DIV_W-1:0] DIV_MASK_2 = 11'h001;

	// compare reset value and counter increment
	localparam logic [CNT_W-1:0] CMP_RESET = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ARMED = 2'h1,
		ST_RUN = 2'h3
	} ppg_run_t;
endpackage
`default_nettype wire

// ### design/ppg_pin_sync.sv
// Purpose: three-flop synchroniser with agreement filter for the trigger pin
// Assumes: pin is asynchronous to i_core_clk
// Notes: level changes only once the second and third stages agree
`default_nettype none
module ppg_pin_sync (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// pin and filtered level
	input wire logic i_pin,
	output logic o_level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} ppg_sync_t;

	ppg_sync_t s_r;
	ppg_sync_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.s1 = i_pin;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		// a one-cycle glitch never reaches the level
		if (s_r.s2 == s_r.s3)
		begin
			s_nxt.lvl = s_r.s3;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign o_level = s_r.lvl;
endmodule
`default_nettype wire

// ### design/ppg_prescaler.sv
// Purpose: source clock tick generator for the pulse counter
// Assumes: free-running divider, one tick pulse per selected period
// Notes: select changes take effect at the next mask match
`default_nettype none
module ppg_prescaler (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// source clock select and tick
	input wire logic [1:0] i_sel,
	output logic o_tick
);
	typedef struct packed {
		logic [ppg_pkg::DIV_W-1:0] cnt;
		logic tick;
	} ppg_div_t;

	ppg_div_t s_r;
	ppg_div_t s_nxt;
	logic [ppg_pkg::DIV_W-1:0] mask;

	always_comb
	begin
		case (i_sel)
			2'h0: mask = ppg_pkg::DIV_MASK_2K;
			2'h1: mask = ppg_pkg::DIV_MASK_128;
			2'h2: mask = ppg_pkg::DIV_MASK_8;
			default: mask = ppg_pkg::DIV_MASK_2;
		endcase
		s_nxt = s_r;
		s_nxt.cnt = s_r.cnt + 11'h001;
		s_nxt.tick = &(s_r.cnt | ~mask);
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign o_tick = s_r.tick;
endmodule
`default_nettype wire

// ### design/ppg_pulse_generator.sv
// Purpose: 16-bit programmable pulse generator with axi4-lite registers
// Assumes: single clock i_core_clk at 100 MHz, synchronous active-high reset
// Notes: ctrl 0x00, period 0x04, width 0x08, status 0x0c (read only)
`default_nettype none

module ppg_pulse_generator (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// axi4-lite write address
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [ppg_pkg::ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic [2:0] i_s_axi_awprot,
	// axi4-lite write data
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	// axi4-lite write response
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	output logic [1:0] o_s_axi_bresp,
	// axi4-lite read address
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	input wire logic [ppg_pkg::ADDR_W-1:0] i_s_axi_araddr,
	input wire logic [2:0] i_s_axi_arprot,
	// axi4-lite read data
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	// pins and events
	input wire logic i_trigger_input_pin,
	output logic o_pulse_output_pin,
	output logic o_timer_one_irq
);
	typedef struct packed {
		// bus side
		logic aw_held;
		logic [ppg_pkg::ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		// timer_one_control
		logic [1:0] timer_mode_field;
		logic [1:0] clk_sel;
		logic [1:0] start_control_field;
		logic pulse_repeat_select;
		logic output_level_init;
		// compare registers, counter and run state
		logic [ppg_pkg::CNT_W-1:0] period_compare_reg;
		logic [ppg_pkg::CNT_W-1:0] width_compare_reg;
		logic [ppg_pkg::CNT_W-1:0] cnt;
		ppg_pkg::ppg_run_t run;
		// output path and trigger edge history
		logic output_toggle_flop;
		logic start_level;
		logic pin;
		logic irq;
		logic trig_d;
	} ppg_state_t;

	ppg_state_t s_r;
	ppg_state_t s_nxt;
	logic src_tick;
	logic trig_level;

	ppg_pin_sync u_trig_sync (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_pin(i_trigger_input_pin),
		.o_level(trig_level)
	);

	ppg_prescaler u_prescaler (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_sel(s_r.clk_sel),
		.o_tick(src_tick)
	);

	always_comb
	begin
		logic [ppg_pkg::CNT_W-1:0] inc;
		logic trig_edge;
		logic counting;
		logic do_wr;
		logic [7:0] ctl;
		logic [1:0] new_start;
		logic [1:0] new_mode;
		logic odd;
		inc = s_r.cnt + ppg_pkg::CNT_ONE;
		trig_edge = 1'b0;
		counting = 1'b0;
		do_wr = 1'b0;
		ctl = i_s_axi_wdata[7:0];
		new_start = 2'h0;
		new_mode = 2'h0;
		odd = 1'b0;
		s_nxt = s_r;
		s_nxt.irq = 1'b0;
		s_nxt.trig_d = trig_level;

		// trigger edge as chosen by the start field
		if (s_r.start_control_field == ppg_pkg::START_RISE)
		begin
			trig_edge = trig_level && !s_r.trig_d;
		end
		else if (s_r.start_control_field == ppg_pkg::START_FALL)
		begin
			trig_edge = !trig_level && s_r.trig_d;
		end

		// timer core
		counting = (s_r.timer_mode_field == ppg_pkg::MODE_PPG) ||
			(s_r.timer_mode_field == ppg_pkg::MODE_TIMER);
		case (s_r.run)
			ppg_pkg::ST_IDLE:
			begin
				s_nxt.run = ppg_pkg::ST_IDLE;
			end
			ppg_pkg::ST_ARMED:
			begin
				if (trig_edge)
				begin
					s_nxt.run = ppg_pkg::ST_RUN;
				end
			end
			ppg_pkg::ST_RUN:
			begin
				// stopped or unsupported modes never compare
				if (src_tick && counting)
				begin
					s_nxt.cnt = inc;
					if (s_r.timer_mode_field == ppg_pkg::MODE_PPG &&
						inc == s_r.width_compare_reg)
					begin
						s_nxt.output_toggle_flop = !s_r.output_toggle_flop;
						s_nxt.irq = 1'b1;
					end
					if (inc == s_r.period_compare_reg)
					begin
						s_nxt.irq = 1'b1;
						s_nxt.cnt = '0;
						if (s_r.timer_mode_field == ppg_pkg::MODE_PPG)
						begin
							s_nxt.output_toggle_flop = !s_nxt.output_toggle_flop;
							if (s_r.pulse_repeat_select)
							begin
								s_nxt.start_control_field = ppg_pkg::START_STOP;
								s_nxt.run = ppg_pkg::ST_IDLE;
							end
						end
					end
				end
			end
			default:
			begin
				s_nxt.run = ppg_pkg::ST_IDLE;
			end
		endcase

		// write channel: address and data may arrive in either order
		if (i_s_axi_awvalid && s_r.awready)
		begin
			s_nxt.aw_held = 1'b1;
			s_nxt.aw_addr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && s_r.wready)
		begin
			s_nxt.w_held = 1'b1;
			s_nxt.w_data = i_s_axi_wdata;
			s_nxt.w_strb = i_s_axi_wstrb;
		end
		if (s_r.bvalid && i_s_axi_bready)
		begin
			s_nxt.bvalid = 1'b0;
		end
		do_wr = s_r.aw_held && s_r.w_held && !s_r.bvalid;
		ctl = s_r.w_data[7:0];
		if (do_wr)
		begin
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = ppg_pkg::AXI_OKAY;
			case (s_r.aw_addr)
				ppg_pkg::ADDR_CTRL:
				begin
					// a software write lands after the one-shot clear in the same cycle
					if (s_r.w_strb[0])
					begin
						new_start = ctl[ppg_pkg::CTL_START_LSB +: 2];
						new_mode = ctl[ppg_pkg::CTL_MODE_LSB +: 2];
						s_nxt.timer_mode_field = new_mode;
						s_nxt.clk_sel = ctl[ppg_pkg::CTL_CLK_LSB +: 2];
						s_nxt.pulse_repeat_select = ctl[ppg_pkg::CTL_REPEAT_BIT];
						s_nxt.output_level_init = ctl[ppg_pkg::CTL_INIT_BIT];
						s_nxt.start_control_field = new_start;
						if (s_r.run == ppg_pkg::ST_IDLE)
						begin
							// flop level only touched while idle; running writes still update the fields and a stop code halts
							odd = s_r.output_toggle_flop ^ s_r.start_level;
							if (new_mode == ppg_pkg::MODE_TIMER)
							begin
								s_nxt.output_toggle_flop = 1'b0;
								s_nxt.start_level = 1'b0;
							end
							else if (new_mode == ppg_pkg::MODE_PPG)
							begin
								s_nxt.output_toggle_flop =
									ctl[ppg_pkg::CTL_INIT_BIT] ^ odd;
							end
							if (new_start != ppg_pkg::START_STOP)
							begin
								s_nxt.cnt = '0;
								s_nxt.start_level = s_nxt.output_toggle_flop;
								s_nxt.run = (new_start == ppg_pkg::START_CMD) ?
									ppg_pkg::ST_RUN : ppg_pkg::ST_ARMED;
							end
						end
						else if (new_start == ppg_pkg::START_STOP)
						begin
							s_nxt.run = ppg_pkg::ST_IDLE;
						end
					end
				end
				ppg_pkg::ADDR_PERIOD:
				begin
					if (s_r.w_strb[0])
					begin
						s_nxt.period_compare_reg[7:0] = s_r.w_data[7:0];
					end
					if (s_r.w_strb[1])
					begin
						s_nxt.period_compare_reg[15:8] = s_r.w_data[15:8];
					end
				end
				ppg_pkg::ADDR_WIDTH:
				begin
					if (s_r.w_strb[0])
					begin
						s_nxt.width_compare_reg[7:0] = s_r.w_data[7:0];
					end
					if (s_r.w_strb[1])
					begin
						s_nxt.width_compare_reg[15:8] = s_r.w_data[15:8];
					end
				end
				ppg_pkg::ADDR_STATUS:
				begin
					s_nxt.bresp = ppg_pkg::AXI_OKAY;
				end
				default:
				begin
					s_nxt.bresp = ppg_pkg::AXI_SLVERR;
				end
			endcase
		end
		s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_held && !s_nxt.bvalid;

		// read channel: one cycle from address to data
		if (s_r.rvalid && i_s_axi_rready)
		begin
			s_nxt.rvalid = 1'b0;
		end
		if (i_s_axi_arvalid && s_r.arready)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = ppg_pkg::AXI_OKAY;
			s_nxt.rdata = '0;
			case (i_s_axi_araddr)
				ppg_pkg::ADDR_CTRL:
				begin
					s_nxt.rdata[ppg_pkg::CTL_MODE_LSB +: 2] = s_r.timer_mode_field;
					s_nxt.rdata[ppg_pkg::CTL_CLK_LSB +: 2] = s_r.clk_sel;
					s_nxt.rdata[ppg_pkg::CTL_START_LSB +: 2] = s_r.start_control_field;
					s_nxt.rdata[ppg_pkg::CTL_REPEAT_BIT] = s_r.pulse_repeat_select;
					s_nxt.rdata[ppg_pkg::CTL_INIT_BIT] = s_r.output_level_init;
				end
				ppg_pkg::ADDR_PERIOD:
				begin
					s_nxt.rdata[15:0] = s_r.period_compare_reg;
				end
				ppg_pkg::ADDR_WIDTH:
				begin
					s_nxt.rdata[15:0] = s_r.width_compare_reg;
				end
				ppg_pkg::ADDR_STATUS:
				begin
					s_nxt.rdata[15:0] = s_r.cnt;
					s_nxt.rdata[ppg_pkg::STAT_FLOP_BIT] = s_r.output_toggle_flop;
					s_nxt.rdata[ppg_pkg::STAT_RUN_BIT] = (s_r.run == ppg_pkg::ST_RUN);
					s_nxt.rdata[ppg_pkg::STAT_ARMED_BIT] = (s_r.run == ppg_pkg::ST_ARMED);
				end
				default:
				begin
					s_nxt.rresp = ppg_pkg::AXI_SLVERR;
				end
			endcase
		end
		s_nxt.arready = !s_nxt.rvalid;

		// pin registered beside the flop so it is never a gate output
		s_nxt.pin = !s_nxt.output_toggle_flop;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			s_r <= '0;
			s_r.period_compare_reg <= ppg_pkg::CMP_RESET;
			s_r.width_compare_reg <= ppg_pkg::CMP_RESET;
			s_r.run <= ppg_pkg::ST_IDLE;
			s_r.pin <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign o_s_axi_awready = s_r.awready;
	assign o_s_axi_wready = s_r.wready;
	assign o_s_axi_bvalid = s_r.bvalid;
	assign o_s_axi_bresp = s_r.bresp;
	assign o_s_axi_arready = s_r.arready;
	assign o_s_axi_rvalid = s_r.rvalid;
	assign o_s_axi_rdata = s_r.rdata;
	assign o_s_axi_rresp = s_r.rresp;
	assign o_pulse_output_pin = s_r.pin;
	assign o_timer_one_irq = s_r.irq;
endmodule
`default_nettype wire

// ### tb/ppg_pulse_generator_monitor.sv
// Purpose: port checks of the pulse generator
// Assumes: one clock, synchronous active-high reset
// Notes: a write may move the pin, so pin moves at a write response are exempt
`default_nettype none
module ppg_pulse_generator_monitor (
	// bus
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_s_axi_awvalid,
	input wire logic o_s_axi_awready,
	input wire logic i_s_axi_wvalid,
	input wire logic o_s_axi_wready,
	input wire logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [1:0] o_s_axi_bresp,
	input wire logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic [ppg_pkg::ADDR_W-1:0] i_s_axi_araddr,
	input wire logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic [1:0] o_s_axi_rresp,
	// pins
	input wire logic o_pulse_output_pin,
	input wire logic o_timer_one_irq
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_srst);
	property p_rst;
		disable iff (1'b0) i_srst |=> o_pulse_output_pin && !o_timer_one_irq && !o_s_axi_bvalid;
	endproperty
	a_rst: assert property (p_rst) else $error("pin not high after reset");
	property p_pin_irq;
		$changed(o_pulse_output_pin) && !$rose(o_s_axi_bvalid) |-> o_timer_one_irq;
	endproperty
	a_pin_irq: assert property (p_pin_irq) else $error("pin moved without irq");
	property p_irq1;
		o_timer_one_irq |=> !o_timer_one_irq;
	endproperty
	a_irq1: assert property (p_irq1) else $error("irq longer than one cycle");
	property p_bhold;
		o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold;
		o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_rlat;
		i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_arblk;
		o_s_axi_rvalid |-> !o_s_axi_arready;
	endproperty
	a_arblk: assert property (p_arblk) else $error("address taken during read data");
	property p_blat;
		i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
			|=> !o_s_axi_bvalid ##1 o_s_axi_bvalid;
	endproperty
	a_blat: assert property (p_blat) else $error("write answer timing");
	property p_slv;
		i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr > 8'h0c
			|=> o_s_axi_rresp == ppg_pkg::AXI_SLVERR && o_s_axi_rdata == 32'h0;
	endproperty
	a_slv: assert property (p_slv) else $error("unmapped read answer");
	c_irq: cover property (o_timer_one_irq);
	c_fall: cover property ($fell(o_pulse_output_pin));
	c_slv: cover property (o_s_axi_bvalid && o_s_axi_bresp == ppg_pkg::AXI_SLVERR);
endmodule
bind ppg_pulse_generator ppg_pulse_generator_monitor i_mon (.i_core_clk, .i_srst,
	.i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bvalid,
	.i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid, .o_s_axi_arready, .i_s_axi_araddr,
	.o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata, .o_s_axi_rresp, .o_pulse_output_pin,
	.o_timer_one_irq);
`default_nettype wire

// ### tb/ppg_trig_model.sv
// Purpose: trigger source driving the trigger pin
// Assumes: edge comes a chosen number of cycles after a request
// Notes: the pin moves off the clock edge, a fixed 3 ns after it
`default_nettype none
module ppg_trig_model (
	// request
	input wire logic i_core_clk,
	input wire logic i_fire,
	input wire logic i_lvl,
	input wire logic [3:0] i_dly,
	// pin
	output logic o_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = -1;
	logic lvl = 1'b0;
	initial o_pin = 1'b0;
	always @(posedge i_core_clk)
	begin
		if (i_fire)
		begin
			cnt <= i_dly;
			lvl <= i_lvl;
		end
		else if (cnt > 0)
			cnt <= cnt - 1;
		else if (cnt == 0)
		begin
			o_pin <= #3 lvl;
			cnt <= -1;
		end
	end
endmodule
`default_nettype wire

// ### tb/ppg_pulse_generator_tb_top.sv
// Purpose: self-checking bench of the pulse generator
// Assumes: source clock /2 selected, so one tick per two cycles
// Notes: expected results queue up, a watcher pops them as outputs appear
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
	$display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module ppg_pulse_generator_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] A_C = ppg_pkg::ADDR_CTRL;
	logic i_core_clk = 0, i_srst = 1, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0;
	logic i_s_axi_bready = 0, i_s_axi_arvalid = 0, i_s_axi_rready = 0, fire = 0, lvl = 0;
	logic [7:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
	logic [2:0] i_s_axi_awprot = 0, i_s_axi_arprot = 0;
	logic [31:0] i_s_axi_wdata = 0, o_s_axi_rdata;
	logic [3:0] i_s_axi_wstrb = 4'hf, dly = 0;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	logic i_trigger_input_pin, o_pulse_output_pin, o_timer_one_irq, pin_q = 1, fall_ok = 0;
	int error_cnt = 0, samples_checked = 0, cyc = 0, irq_cnt = 0, q_low[$];
	time t_fall;
	logic [1:0] q_b[$];
	logic [65:0] q_r[$];
	ppg_pulse_generator i_dut (.i_core_clk, .i_srst, .i_s_axi_awvalid, .o_s_axi_awready,
		.i_s_axi_awaddr, .i_s_axi_awprot, .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata,
		.i_s_axi_wstrb, .o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid,
		.o_s_axi_arready, .i_s_axi_araddr, .i_s_axi_arprot, .o_s_axi_rvalid, .i_s_axi_rready,
		.o_s_axi_rdata, .o_s_axi_rresp, .i_trigger_input_pin, .o_pulse_output_pin,
		.o_timer_one_irq);
	ppg_trig_model i_trig (.i_core_clk, .i_fire(fire), .i_lvl(lvl), .i_dly(dly),
		.o_pin(i_trigger_input_pin));
	initial
	begin
		forever #5 i_core_clk = ~i_core_clk;
	end
	task automatic end_of_test();
		if (error_cnt == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bit aw, w;
		aw = 1;
		w = 1;
		q_b.push_back(r);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1;
		i_s_axi_wvalid <= 1;
		i_s_axi_bready <= 1;
		do
		begin
			@(posedge i_core_clk);
			if (o_s_axi_awready)
				aw = 0;
			if (o_s_axi_wready)
				w = 0;
			i_s_axi_awvalid <= aw;
			i_s_axi_wvalid <= w;
		end
		while (aw || w);
		do @(posedge i_core_clk); while (!o_s_axi_bvalid);
		i_s_axi_bready <= 0;
		@(posedge i_core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, m, input logic [1:0] r);
		q_r.push_back({r, m, d});
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1;
		i_s_axi_rready <= 1;
		do @(posedge i_core_clk); while (!o_s_axi_arready);
		i_s_axi_arvalid <= 0;
		do @(posedge i_core_clk); while (!o_s_axi_rvalid);
		i_s_axi_rready <= 0;
		@(posedge i_core_clk);
	endtask
	task automatic wait_pin(input logic v);
		do @(posedge i_core_clk); while (o_pulse_output_pin !== v);
	endtask
	always @(posedge i_core_clk)
	begin
		logic [65:0] e;
		logic [1:0] eb;
		int el;
		cyc++;
		if (cyc == 60000)
		begin
			error_cnt++;
			end_of_test();
		end
		if (o_timer_one_irq)
			irq_cnt++;
		// pop once: the compare macro names its expected value twice
		if (o_s_axi_bvalid && i_s_axi_bready)
		begin
			eb = q_b.pop_front();
			`CHK(o_s_axi_bresp, eb)
		end
		if (o_s_axi_rvalid && i_s_axi_rready)
		begin
			e = q_r.pop_front();
			`CHK(o_s_axi_rdata & e[63:32], e[31:0])
			`CHK(o_s_axi_rresp, e[65:64])
		end
		if (o_timer_one_irq && pin_q && !o_pulse_output_pin)
		begin
			t_fall = $time;
			fall_ok = 1;
		end
		if (o_timer_one_irq && !pin_q && o_pulse_output_pin)
		begin
			if (fall_ok && q_low.size() > 0)
			begin
				el = q_low.pop_front();
				`CHK(($time - t_fall) / 10, el)
			end
			fall_ok = 0;
		end
		pin_q = o_pulse_output_pin;
	end
	initial
	begin
		int p, w, st;
		void'($urandom(55353));
		repeat (10) @(posedge i_core_clk);
		i_srst <= 0;
		repeat (2) @(posedge i_core_clk);
		`CHK(o_pulse_output_pin, 1'b1)
		rd(A_C, 0, '1, 0);
		rd(8'h04, 32'hffff, '1, 0);
		rd(8'h0c, 0, '1, 0);
		rd(8'h10, 0, '1, 2);
		wr(8'h10, 1, 2);
		wr(8'h0c, 1, 0);
		p = 20 + $urandom % 20;
		w = 3 + $urandom % (p - 10);
		wr(A_C, 32'h0f, 0);
		wr(8'h04, p, 0);
		wr(8'h08, w, 0);
		q_low.push_back(2 * (p - w));
		q_low.push_back(2 * (p - w));
		wr(A_C, 32'h1f, 0);
		repeat (2)
		begin
			wait_pin(0);
			wait_pin(1);
		end
		wait_pin(0);
		wr(A_C, 32'h0f, 0);
		st = irq_cnt;
		repeat (4 * p) @(posedge i_core_clk);
		`CHK(o_pulse_output_pin, 1'b0)
		`CHK(irq_cnt, st)
		rd(8'h0c, 32'h10000, 32'h70000, 0);
		wr(A_C, 32'h8f, 0);
		`CHK(o_pulse_output_pin, 1'b1)
		wr(A_C, 32'h0c, 0);
		st = irq_cnt;
		wr(A_C, 32'hdf, 0);
		`CHK(o_pulse_output_pin, 1'b0)
		repeat (2 * p + 20) @(posedge i_core_clk);
		`CHK(irq_cnt - st, 2)
		`CHK(o_pulse_output_pin, 1'b0)
		rd(A_C, 32'hcf, 32'hff, 0);
		wr(A_C, 32'h0c, 0);
		for (int k = 2; k < 4; k++)
		begin
			wr(A_C, 32'h0f | (k << 4), 0);
			rd(8'h0c, 32'h40000, 32'h60000, 0);
			lvl <= (k == 2);
			dly <= $urandom % 8;
			fire <= 1;
			@(posedge i_core_clk);
			fire <= 0;
			repeat (30) @(posedge i_core_clk);
			rd(8'h0c, 32'h20000, 32'h60000, 0);
			wr(A_C, 32'h0f, 0);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
